/* timer_evt_pkg.sv */
// constants and types shared by the timer event and output-compare control block
package timer_evt_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_CH = 4;
  localparam int OC_CH = 2;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVTGEN = 8'h14;
  localparam logic [7:0] OFS_MODE12 = 8'h18;
  localparam logic [7:0] OFS_CHAN_CTRL = 8'h20;
  localparam logic [7:0] OFS_CC [NUM_CH] = '{8'h34, 8'h38, 8'h3c, 8'h40};

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // event_generation bits
  localparam int EG_UPD = 0;
  localparam int EG_CH_LO = 1;
  localparam int EG_TRIG = 6;

  // status bits
  localparam int ST_UPD = 0;
  localparam int ST_CH_LO = 1;
  localparam int ST_TRIG = 6;
  localparam int ST_OVR_LO = 9;
  localparam logic [15:0] ST_MASK = 16'h1e5f;

  // channel_mode_1_2 fields, channel 2 sits one stride higher
  localparam int CH_STRIDE = 8;
  localparam int SEL_LO = 0;
  localparam int FEN_BIT = 2;
  localparam int PEN_BIT = 3;
  localparam int MODE_LO = 4;
  localparam int CEN_BIT = 7;

  // channel control register: enables then polarities
  localparam int CTL_EN_LO = 0;
  localparam int CTL_POL_LO = 4;

  // wait bound for the trigger-to-reference change with fast enable set, in clocks; the path itself takes two
  localparam int FAST_LAT_CYC = 3;

  typedef enum logic [1:0] {
    SEL_OUT = 2'b00,
    SEL_PIN_OWN = 2'b01,
    SEL_PIN_OTHER = 2'b10,
    SEL_TRIG = 2'b11
  } chan_sel_t;

  typedef enum logic [2:0] {
    OC_FROZEN = 3'b000,
    OC_SET = 3'b001,
    OC_CLEAR = 3'b010,
    OC_TOGGLE = 3'b011,
    OC_FORCE_LO = 3'b100,
    OC_FORCE_HI = 3'b101,
    OC_PWM1 = 3'b110,
    OC_PWM2 = 3'b111
  } oc_mode_t;

endpackage : timer_evt_pkg

/* timer_event_ctl.sv */
// event generation, channel mode control and output-compare reference logic
`timescale 1ns/1ps
module timer_event_ctl #(
  parameter int COUNT_W = timer_evt_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  input wire logic [15:0] counterValue,
  input wire logic countDown,
  input wire logic [15:0] autoReloadValue,
  input wire logic counterUpdate,
  input wire logic triggerEdge,
  input wire logic internalTriggerSelected,
  input wire logic captureEdgeA,
  input wire logic captureEdgeB,
  input wire logic captureEdgeTrig,
  input wire logic [1:0] chan34Input,
  input wire logic [1:0] chan34CaptureEdge,
  input wire logic extTriggerPin,
  output logic updateEventOut,
  output logic [15:0] counterLoadValue,
  output logic triggerEventOut,
  output logic [15:0] statusFlags,
  output logic [1:0] chanRef,
  output logic [1:0] chanOut,
  output logic [1:0] chanOutN
);

  if (COUNT_W != timer_evt_pkg::DATA_W) begin : g_width_check
    $error("COUNT_W must equal the 16-bit register width");
  end

  typedef struct packed {
    logic [15:0] rdData;
    logic [6:0] evtReq;
    logic [15:0] status;
    logic [15:0] mode;
    logic [7:0] ctrl;
    logic [3:0][15:0] ccActive;
    logic [1:0][15:0] ccShadow;
    logic [1:0] oref;
    logic [1:0] pwmPrev;
    logic [1:0][2:0] modePrev;
    logic [1:0] matchPrev;
    logic [2:0] etrSync;
    logic etrLevel;
    logic trigDly;
    logic updOut;
    logic trigOut;
    logic [15:0] loadVal;
    logic [1:0] outP;
    logic [1:0] outN;
  } state_t;

  state_t st_reg;
  state_t st_next;

  function automatic logic [1:0] selOf(input logic [15:0] m, input int ch);
    selOf = m[ch * timer_evt_pkg::CH_STRIDE + timer_evt_pkg::SEL_LO +: 2];
  endfunction : selOf

  function automatic logic [2:0] modeOf(input logic [15:0] m, input int ch);
    modeOf = m[ch * timer_evt_pkg::CH_STRIDE + timer_evt_pkg::MODE_LO +: 3];
  endfunction : modeOf

  function automatic logic bitOf(input logic [15:0] m, input int ch, input int pos);
    bitOf = m[ch * timer_evt_pkg::CH_STRIDE + pos];
  endfunction : bitOf

  // PWM1 level; PWM2 is its inverse
  function automatic logic pwmLevel(input logic [2:0] md, input logic [15:0] cnt, input logic [15:0] cmp,
                                    input logic down);
    logic lvl;
    lvl = down ? !(cnt > cmp) : (cnt < cmp);
    pwmLevel = (md == timer_evt_pkg::OC_PWM2) ? !lvl : lvl;
  endfunction : pwmLevel

  always_comb begin
    logic isIn;
    logic hwEdge;
    logic swEv;
    logic capture;
    logic match;
    logic lvl;
    logic upd;
    logic [2:0] md;
    logic [1:0] sel;
    logic nref;
    logic [15:0] keepSel;
    isIn = 1'b0;
    hwEdge = 1'b0;
    swEv = 1'b0;
    capture = 1'b0;
    match = 1'b0;
    lvl = 1'b0;
    upd = 1'b0;
    md = timer_evt_pkg::OC_FROZEN;
    sel = timer_evt_pkg::SEL_OUT;
    nref = 1'b0;
    keepSel = timer_evt_pkg::RST_WORD;
    st_next = st_reg;
    st_next.evtReq = '0;
    st_next.updOut = 1'b0;
    st_next.trigOut = 1'b0;
    st_next.rdData = timer_evt_pkg::RST_WORD;
    upd = st_reg.evtReq[timer_evt_pkg::EG_UPD] || counterUpdate;

    // external trigger: change accepted once stages two and three agree
    st_next.etrSync = {st_reg.etrSync[1:0], extTriggerPin};
    if (st_reg.etrSync[1] == st_reg.etrSync[2]) begin
      st_next.etrLevel = st_reg.etrSync[2];
    end
    st_next.trigDly = triggerEdge;

    // register reads
    if (regRead) begin
      case (regAddr)
        timer_evt_pkg::OFS_STATUS: st_next.rdData = st_reg.status;
        timer_evt_pkg::OFS_EVTGEN: st_next.rdData = timer_evt_pkg::RST_WORD;
        timer_evt_pkg::OFS_MODE12: st_next.rdData = st_reg.mode;
        timer_evt_pkg::OFS_CHAN_CTRL: st_next.rdData = {8'h00, st_reg.ctrl};
        default: st_next.rdData = timer_evt_pkg::RST_WORD;
      endcase
      for (int i = 0; i < timer_evt_pkg::NUM_CH; i++) begin
        if (regAddr == timer_evt_pkg::OFS_CC[i]) begin
          isIn = (i < timer_evt_pkg::OC_CH) ? (selOf(st_reg.mode, i) != timer_evt_pkg::SEL_OUT)
                                            : chan34Input[i - timer_evt_pkg::OC_CH];
          if (!isIn && i < timer_evt_pkg::OC_CH && bitOf(st_reg.mode, i, timer_evt_pkg::PEN_BIT)) begin
            st_next.rdData = st_reg.ccShadow[i];
          end else begin
            st_next.rdData = st_reg.ccActive[i];
          end
          // reading a captured value acknowledges its flag
          if (isIn) begin
            st_next.status[timer_evt_pkg::ST_CH_LO + i] = 1'b0;
          end
        end
      end
    end

    // register writes
    if (regWrite) begin
      case (regAddr)
        timer_evt_pkg::OFS_STATUS: begin
          st_next.status = st_reg.status & regWrData & timer_evt_pkg::ST_MASK;
        end
        timer_evt_pkg::OFS_EVTGEN: begin
          // zeros leave requests alone; only ones start events
          st_next.evtReq = regWrData[6:0] & 7'h5f;
        end
        timer_evt_pkg::OFS_MODE12: begin
          keepSel = regWrData;
          for (int i = 0; i < timer_evt_pkg::OC_CH; i++) begin
            if (st_reg.ctrl[timer_evt_pkg::CTL_EN_LO + i]) begin
              keepSel[i * timer_evt_pkg::CH_STRIDE + timer_evt_pkg::SEL_LO +: 2] = selOf(st_reg.mode, i);
            end
          end
          st_next.mode = keepSel;
        end
        timer_evt_pkg::OFS_CHAN_CTRL: st_next.ctrl = regWrData[7:0];
        default: st_next.ctrl = st_reg.ctrl;
      endcase
      for (int i = 0; i < timer_evt_pkg::OC_CH; i++) begin
        if (regAddr == timer_evt_pkg::OFS_CC[i] && selOf(st_reg.mode, i) == timer_evt_pkg::SEL_OUT) begin
          st_next.ccShadow[i] = regWrData;
          if (!bitOf(st_reg.mode, i, timer_evt_pkg::PEN_BIT)) begin
            st_next.ccActive[i] = regWrData;
          end
        end
      end
    end

    // update and trigger events issued the cycle after the request
    if (st_reg.evtReq[timer_evt_pkg::EG_UPD]) begin
      st_next.updOut = 1'b1;
      st_next.loadVal = countDown ? autoReloadValue : timer_evt_pkg::CNT_ZERO;
    end
    if (st_reg.evtReq[timer_evt_pkg::EG_TRIG]) begin
      st_next.trigOut = 1'b1;
      st_next.status[timer_evt_pkg::ST_TRIG] = 1'b1;
    end
    if (upd) begin
      st_next.status[timer_evt_pkg::ST_UPD] = 1'b1;
      for (int i = 0; i < timer_evt_pkg::OC_CH; i++) begin
        // in input mode this bit is a prescaler setting, so a capture must survive
        if (bitOf(st_reg.mode, i, timer_evt_pkg::PEN_BIT) && selOf(st_reg.mode, i) == timer_evt_pkg::SEL_OUT) begin
          st_next.ccActive[i] = st_reg.ccShadow[i];
        end
      end
    end

    // per-channel capture and flags
    for (int i = 0; i < timer_evt_pkg::NUM_CH; i++) begin
      swEv = st_reg.evtReq[timer_evt_pkg::EG_CH_LO + i];
      if (i < timer_evt_pkg::OC_CH) begin
        sel = selOf(st_reg.mode, i);
        isIn = (sel != timer_evt_pkg::SEL_OUT);
        case (sel)
          timer_evt_pkg::SEL_PIN_OWN: hwEdge = (i == 0) ? captureEdgeA : captureEdgeB;
          timer_evt_pkg::SEL_PIN_OTHER: hwEdge = (i == 0) ? captureEdgeB : captureEdgeA;
          timer_evt_pkg::SEL_TRIG: hwEdge = captureEdgeTrig && internalTriggerSelected;
          default: hwEdge = 1'b0;
        endcase
        match = (counterValue == st_reg.ccActive[i]) && !st_reg.matchPrev[i];
      end else begin
        isIn = chan34Input[i - timer_evt_pkg::OC_CH];
        hwEdge = chan34CaptureEdge[i - timer_evt_pkg::OC_CH];
        match = 1'b0;
      end
      hwEdge = hwEdge && st_reg.ctrl[timer_evt_pkg::CTL_EN_LO + i];
      if (isIn) begin
        capture = swEv || hwEdge;
        if (capture) begin
          st_next.ccActive[i] = counterValue;
          st_next.status[timer_evt_pkg::ST_CH_LO + i] = 1'b1;
          if (st_reg.status[timer_evt_pkg::ST_CH_LO + i]) begin
            st_next.status[timer_evt_pkg::ST_OVR_LO + i] = 1'b1;
          end
        end
      end else if (swEv || match) begin
        st_next.status[timer_evt_pkg::ST_CH_LO + i] = 1'b1;
      end
    end

    // output reference for channels 1 and 2
    for (int i = 0; i < timer_evt_pkg::OC_CH; i++) begin
      md = modeOf(st_reg.mode, i);
      match = (counterValue == st_reg.ccActive[i]);
      lvl = pwmLevel(md, counterValue, st_reg.ccActive[i], countDown);
      nref = st_reg.oref[i];
      case (md)
        timer_evt_pkg::OC_FROZEN: nref = st_reg.oref[i];
        timer_evt_pkg::OC_SET: if (match && !st_reg.matchPrev[i]) nref = 1'b1;
        timer_evt_pkg::OC_CLEAR: if (match && !st_reg.matchPrev[i]) nref = 1'b0;
        timer_evt_pkg::OC_TOGGLE: if (match && !st_reg.matchPrev[i]) nref = !st_reg.oref[i];
        timer_evt_pkg::OC_FORCE_LO: nref = 1'b0;
        timer_evt_pkg::OC_FORCE_HI: nref = 1'b1;
        timer_evt_pkg::OC_PWM1, timer_evt_pkg::OC_PWM2: begin
          if (lvl != st_reg.pwmPrev[i] || st_reg.modePrev[i] == timer_evt_pkg::OC_FROZEN) begin
            nref = lvl;
          end
          // fast path: a trigger edge lands on the up-counting post-match level
          if (bitOf(st_reg.mode, i, timer_evt_pkg::FEN_BIT) && st_reg.trigDly) begin
            nref = (md == timer_evt_pkg::OC_PWM2);
          end
        end
        default: nref = st_reg.oref[i];
      endcase
      if (bitOf(st_reg.mode, i, timer_evt_pkg::CEN_BIT) && st_reg.etrLevel) begin
        nref = 1'b0;
      end
      // input channels have no reference to drive
      if (selOf(st_reg.mode, i) != timer_evt_pkg::SEL_OUT) begin
        nref = 1'b0;
      end
      st_next.oref[i] = nref;
      st_next.pwmPrev[i] = lvl;
      st_next.modePrev[i] = md;
      st_next.matchPrev[i] = match;
      // active-high reference, each output flipped by its own polarity bit
      st_next.outP[i] = st_reg.ctrl[timer_evt_pkg::CTL_EN_LO + i] &&
                        (nref ^ st_reg.ctrl[timer_evt_pkg::CTL_POL_LO + 2 * i]);
      st_next.outN[i] = st_reg.ctrl[timer_evt_pkg::CTL_EN_LO + i] &&
                        (nref ^ st_reg.ctrl[timer_evt_pkg::CTL_POL_LO + 2 * i + 1]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdData = st_reg.rdData;
  assign updateEventOut = st_reg.updOut;
  assign counterLoadValue = st_reg.loadVal;
  assign triggerEventOut = st_reg.trigOut;
  assign statusFlags = st_reg.status;
  assign chanRef = st_reg.oref;
  assign chanOut = st_reg.outP;
  assign chanOutN = st_reg.outN;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence trigWrite;
    regWrite && regAddr == timer_evt_pkg::OFS_EVTGEN && regWrData[timer_evt_pkg::EG_TRIG];
  endsequence

  // either pwm mode; mode bit 4 gives the up-counting post-match level to expect
  sequence fastEdgePwm;
    triggerEdge && st_reg.mode[timer_evt_pkg::FEN_BIT] && st_reg.mode[6:5] == 2'b11 &&
    !st_reg.mode[timer_evt_pkg::CEN_BIT] && selOf(st_reg.mode, 0) == timer_evt_pkg::SEL_OUT;
  endsequence

  chk_trig_event_flag: assert property (trigWrite |-> ##2 (triggerEventOut && statusFlags[timer_evt_pkg::ST_TRIG]) ##1 !triggerEventOut)
    else $error("trigger request did not raise one event and the flag");

  chk_update_reload: assert property (regWrite && regAddr == timer_evt_pkg::OFS_EVTGEN && regWrData[0] ##1 1'b1 |=>
    updateEventOut && counterLoadValue == ($past(countDown) ? $past(autoReloadValue) : timer_evt_pkg::CNT_ZERO))
    else $error("update request gave a wrong reload value");

  chk_evtgen_zero: assert property (regRead && regAddr == timer_evt_pkg::OFS_EVTGEN |=> regRdData == 16'h0000)
    else $error("event generation register read non-zero");

  chk_sw_compare_flag: assert property (selOf(st_reg.mode, 0) == timer_evt_pkg::SEL_OUT && st_reg.evtReq[1] |=>
    statusFlags[timer_evt_pkg::ST_CH_LO])
    else $error("software compare event did not set the channel flag");

  chk_sel_locked: assert property (regWrite && regAddr == timer_evt_pkg::OFS_MODE12 && st_reg.ctrl[1] |=>
    st_reg.mode[9:8] == $past(st_reg.mode[9:8]))
    else $error("channel 2 select changed while enabled");

  chk_trig_sel_gate: assert property (selOf(st_reg.mode, 1) == timer_evt_pkg::SEL_TRIG && st_reg.ctrl[1] &&
    captureEdgeTrig && !st_reg.status[2] && !st_reg.evtReq[2] |=> statusFlags[2] == $past(internalTriggerSelected))
    else $error("internal trigger capture ignored its source gate");

  chk_overcapture_set: assert property (selOf(st_reg.mode, 0) != timer_evt_pkg::SEL_OUT && st_reg.status[1] &&
    (st_reg.evtReq[1] || (selOf(st_reg.mode, 0) == timer_evt_pkg::SEL_PIN_OWN && st_reg.ctrl[0] && captureEdgeA)) |=>
    st_reg.status[timer_evt_pkg::ST_OVR_LO] && st_reg.ccActive[0] == $past(counterValue))
    else $error("capture with flag set missed value or overcapture");

  chk_force_levels: assert property (selOf(st_reg.mode, 0) == timer_evt_pkg::SEL_OUT &&
    modeOf(st_reg.mode, 0) == timer_evt_pkg::OC_FORCE_HI && !(st_reg.mode[7] && st_reg.etrLevel) |=> chanRef[0])
    else $error("force high did not hold reference high");

  chk_etr_clear: assert property (st_reg.mode[timer_evt_pkg::CEN_BIT] && st_reg.etrLevel |=> !chanRef[0])
    else $error("external trigger did not clear reference");

  chk_frozen_hold: assert property (selOf(st_reg.mode, 0) == timer_evt_pkg::SEL_OUT &&
    modeOf(st_reg.mode, 0) == timer_evt_pkg::OC_FROZEN && !(st_reg.mode[7] && st_reg.etrLevel) |=> $stable(chanRef[0]))
    else $error("frozen mode changed reference");

  chk_fast_trigger: assert property (fastEdgePwm ##1 $stable(st_reg.mode[7:0]) |=>
    chanRef[0] == $past(st_reg.mode[timer_evt_pkg::MODE_LO]))
    else $error("fast trigger missed its latency");

  chk_polarity_out: assert property (st_reg.ctrl[0] |=> chanOut[0] == (chanRef[0] ^ $past(st_reg.ctrl[4])))
    else $error("channel output ignores polarity");

endmodule : timer_event_ctl

/* tb.sv */
// self-checking testbench for the timer event and output-compare control block
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] EVT_A = timer_evt_pkg::OFS_EVTGEN;
  localparam logic [7:0] MODE_A = timer_evt_pkg::OFS_MODE12;
  localparam logic [7:0] STAT_A = timer_evt_pkg::OFS_STATUS;
  localparam logic [7:0] CTL_A = timer_evt_pkg::OFS_CHAN_CTRL;
  localparam logic [7:0] CC1_A = timer_evt_pkg::OFS_CC[0];
  logic mclk;
  logic rst;
  logic [7:0] regAddr;
  logic [15:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [15:0] regRdData;
  logic [15:0] counterValue;
  logic countDown;
  logic [15:0] autoReloadValue;
  logic counterUpdate;
  logic triggerEdge;
  logic captureEdgeA;
  logic internalTriggerSelected;
  logic captureEdgeTrig;
  logic extTriggerPin;
  logic updateEventOut;
  logic [15:0] counterLoadValue;
  logic triggerEventOut;
  logic [15:0] statusFlags;
  logic [1:0] chanRef;
  logic [1:0] chanOut;
  logic [1:0] chanOutN;
  int miscompares;
  int checks_done;
  // mode sequence chosen so each step but the last (force low) leaves a different reference level than a broken mode would
  logic [2:0] modeSeq [6] = '{3'h5, 3'h0, 3'h2, 3'h1, 3'h3, 3'h4};
  logic refSeq [6] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};

  timer_event_ctl u_timer_event_ctl (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .counterValue(counterValue), .countDown(countDown),
    .autoReloadValue(autoReloadValue), .counterUpdate(counterUpdate), .triggerEdge(triggerEdge),
    .internalTriggerSelected(internalTriggerSelected), .captureEdgeA(captureEdgeA), .captureEdgeB(1'h0),
    .captureEdgeTrig(captureEdgeTrig), .chan34Input(2'h0), .chan34CaptureEdge(2'h0), .extTriggerPin(extTriggerPin),
    .updateEventOut(updateEventOut), .counterLoadValue(counterLoadValue),
    .triggerEventOut(triggerEventOut), .statusFlags(statusFlags), .chanRef(chanRef),
    .chanOut(chanOut), .chanOutN(chanOutN)
  );

  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  task automatic final_report;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk1(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWrite <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'h0;
  endtask : wr

  // read data only stands in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'h0;
    #1;
    chk(regRdData, exp);
  endtask : rd

  // bounded wait on the channel 1 reference; expiry ends the run
  task automatic wait_ref(input logic val, input int lim);
    int n;
    n = 0;
    while (chanRef[0] !== val && n < lim) begin
      tick(1);
      n++;
    end
    checks_done++;
    if (chanRef[0] !== val) begin
      miscompares++;
      $display("unexpected reference at %0t: seen %h expected %h", $time, chanRef[0], val);
      final_report();
    end
  endtask : wait_ref

  initial begin
    miscompares = 0;
    checks_done = 0;
    rst = 1'h1;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrite = 1'h0;
    regRead = 1'h0;
    // counter kept off the reset compare value so no match flag appears early
    counterValue = 16'h0100;
    countDown = 1'h1;
    autoReloadValue = 16'h1234;
    counterUpdate = 1'h0;
    triggerEdge = 1'h0;
    captureEdgeA = 1'h0;
    internalTriggerSelected = 1'h0;
    captureEdgeTrig = 1'h0;
    extTriggerPin = 1'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    rd(EVT_A, 16'h0000);
    rd(MODE_A, 16'h0000);
    wr(8'h7c, 16'hffff);
    rd(8'h7c, 16'h0000);
    rd(MODE_A, 16'h0000);
    $display("test reset finished");
    wr(EVT_A, 16'h0040);
    tick(1);
    chk1(triggerEventOut, 1'h1);
    chk(statusFlags, 16'h0040);
    tick(1);
    chk1(triggerEventOut, 1'h0);
    wr(EVT_A, 16'h0001);
    tick(1);
    chk1(updateEventOut, 1'h1);
    chk(counterLoadValue, 16'h1234);
    @(posedge mclk) countDown <= 1'h0;
    wr(EVT_A, 16'h0001);
    tick(1);
    chk(counterLoadValue, 16'h0000);
    chk(statusFlags, 16'h0041);
    wr(EVT_A, 16'h001e);
    tick(2);
    chk(statusFlags, 16'h005f);
    wr(STAT_A, 16'h0000);
    wr(EVT_A, 16'hffa0);
    tick(2);
    chk(statusFlags, 16'h0000);
    chk1(triggerEventOut | updateEventOut, 1'h0);
    rd(EVT_A, 16'h0000);
    $display("test events finished");
    wr(MODE_A, 16'h0001);
    @(posedge mclk) counterValue <= 16'h0abc;
    wr(EVT_A, 16'h0002);
    tick(2);
    chk(statusFlags, 16'h0002);
    // pin edges only capture on an enabled channel
    wr(CTL_A, 16'h0001);
    @(posedge mclk) counterValue <= 16'h0def;
    captureEdgeA <= 1'h1;
    @(posedge mclk) captureEdgeA <= 1'h0;
    tick(2);
    chk(statusFlags, 16'h0202);
    rd(CC1_A, 16'h0def);
    wr(STAT_A, 16'h0000);
    @(posedge mclk) counterValue <= 16'h0123;
    wr(EVT_A, 16'h0002);
    tick(2);
    rd(CC1_A, 16'h0123);
    $display("test capture finished");
    wr(CTL_A, 16'h0002);
    wr(MODE_A, 16'h0101);
    rd(MODE_A, 16'h0001);
    wr(CTL_A, 16'h0000);
    wr(MODE_A, 16'h0101);
    rd(MODE_A, 16'h0101);
    wr(MODE_A, 16'hfc00);
    rd(MODE_A, 16'hfc00);
    wr(MODE_A, 16'h0300);
    wr(CTL_A, 16'h0002);
    @(posedge mclk) captureEdgeTrig <= 1'h1;
    @(posedge mclk) captureEdgeTrig <= 1'h0;
    tick(2);
    chk1(statusFlags[2], 1'h0);
    @(posedge mclk) internalTriggerSelected <= 1'h1;
    captureEdgeTrig <= 1'h1;
    @(posedge mclk) captureEdgeTrig <= 1'h0;
    tick(2);
    chk1(statusFlags[2], 1'h1);
    @(posedge mclk) internalTriggerSelected <= 1'h0;
    wr(CTL_A, 16'h0000);
    wr(STAT_A, 16'h0000);
    wr(MODE_A, 16'h0000);
    $display("test select finished");
    wr(CC1_A, 16'h0010);
    @(posedge mclk) counterValue <= 16'h0000;
    for (int i = 0; i < 6; i++) begin
      wr(MODE_A, {9'h000, modeSeq[i], 4'h0});
      @(posedge mclk) counterValue <= 16'h0010;
      tick(3);
      chk1(chanRef[0], refSeq[i]);
      @(posedge mclk) counterValue <= 16'h0000;
    end
    // pass through frozen so the pwm entry takes the comparison level
    wr(MODE_A, 16'h0000);
    wr(MODE_A, 16'h0068);
    tick(3);
    chk1(chanRef[0], 1'h1);
    @(posedge mclk) counterValue <= 16'h0020;
    tick(3);
    chk1(chanRef[0], 1'h0);
    @(posedge mclk) countDown <= 1'h1;
    @(posedge mclk) counterValue <= 16'h0005;
    tick(3);
    chk1(chanRef[0], 1'h1);
    wr(MODE_A, 16'h0000);
    wr(MODE_A, 16'h0078);
    tick(3);
    chk1(chanRef[0], 1'h0);
    @(posedge mclk) counterValue <= 16'h0020;
    tick(3);
    chk1(chanRef[0], 1'h1);
    @(posedge mclk) countDown <= 1'h0;
    $display("test compare finished");
    wr(MODE_A, 16'h0050);
    wr(CTL_A, 16'h0001);
    tick(2);
    chk({14'h0000, chanOut[0], chanOutN[0]}, 16'h0003);
    wr(CTL_A, 16'h0011);
    tick(2);
    chk({14'h0000, chanOut[0], chanOutN[0]}, 16'h0001);
    wr(CTL_A, 16'h0021);
    tick(2);
    chk({14'h0000, chanOut[0], chanOutN[0]}, 16'h0002);
    wr(CTL_A, 16'h0000);
    // preload: shadow holds the new compare until an update arrives
    wr(MODE_A, 16'h0040);
    wr(MODE_A, 16'h0018);
    wr(CC1_A, 16'h0030);
    rd(CC1_A, 16'h0030);
    @(posedge mclk) counterValue <= 16'h0030;
    tick(3);
    chk1(chanRef[0], 1'h0);
    @(posedge mclk) counterValue <= 16'h0000;
    @(posedge mclk) counterUpdate <= 1'h1;
    @(posedge mclk) counterUpdate <= 1'h0;
    @(posedge mclk) counterValue <= 16'h0030;
    tick(3);
    chk1(chanRef[0], 1'h1);
    $display("test preload finished");
    @(posedge mclk) counterValue <= 16'h0005;
    wr(MODE_A, 16'h0000);
    wr(MODE_A, 16'h006c);
    tick(3);
    chk1(chanRef[0], 1'h1);
    @(posedge mclk) triggerEdge <= 1'h1;
    @(posedge mclk) triggerEdge <= 1'h0;
    wait_ref(1'h0, timer_evt_pkg::FAST_LAT_CYC);
    tick(4);
    chk1(chanRef[0], 1'h0);
    wr(MODE_A, 16'h0068);
    @(posedge mclk) counterValue <= 16'h0040;
    tick(3);
    @(posedge mclk) counterValue <= 16'h0005;
    wait_ref(1'h1, 4);
    @(posedge mclk) extTriggerPin <= 1'h1;
    tick(8);
    chk1(chanRef[0], 1'h1);
    @(posedge mclk) extTriggerPin <= 1'h0;
    // let the synchronised level fall before clear enable goes on
    tick(8);
    wr(MODE_A, 16'h00e8);
    tick(2);
    chk1(chanRef[0], 1'h1);
    @(posedge mclk) extTriggerPin <= 1'h1;
    wait_ref(1'h0, 8);
    @(posedge mclk) extTriggerPin <= 1'h0;
    $display("test fast and clear finished");
    final_report();
  end
endmodule : tb
